// >>> uipc_pkg.sv
// Shared constants, encodings and carrier types for the UART interrupt, parity and error block.
// Assumes a single clock domain; every user of these types imports the whole package.
`default_nettype none
package uipc_pkg;

  // ---------------------------------------------------------------
  // Interrupt source bit positions, one layout for all views
  // ---------------------------------------------------------------
  localparam int IRQ_N               = 11;
  localparam int irq_overrun         = 0;
  localparam int irq_line_break      = 1;
  localparam int irq_parity_fault    = 2;
  localparam int irq_frame_fault     = 3;
  localparam int irq_rx_idle_timeout = 4;
  localparam int irq_tx              = 5;
  localparam int irq_rx              = 6;
  localparam int irq_dsr             = 7;
  localparam int irq_dcd             = 8;
  localparam int irq_cts             = 9;
  localparam int irq_ri              = 10;

  typedef logic [IRQ_N-1:0] uipc_irq_t;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    th_one_eighth,
    th_two_eighths,
    th_four_eighths,
    th_six_eighths,
    th_seven_eighths
  } uipc_thresh_e;

  typedef enum logic [2:0] {
    parity_off,
    parity_even_sel,
    parity_odd_sel,
    parity_stick_high,
    parity_stick_low
  } uipc_parity_e;

  typedef enum logic {
    tx_irq_on_level,
    tx_irq_on_idle
  } uipc_txmode_e;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rx_err_overflow;
    logic rx_err_line_break;
    logic rx_err_parity_bit;
    logic rx_err_frame;
  } uipc_rx_err_s;

  typedef struct packed {
    logic ri;
    logic cts;
    logic dcd;
    logic dsr;
  } uipc_modem_s;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam uipc_thresh_e TX_THRESH_RST = th_four_eighths;
  localparam uipc_thresh_e RX_THRESH_RST = th_four_eighths;
  localparam uipc_parity_e PARITY_RST    = parity_off;
  localparam uipc_txmode_e TX_MODE_RST   = tx_irq_on_level;
  localparam uipc_irq_t    IRQ_EN_RST    = 11'h000;
  localparam uipc_irq_t    IRQ_RAW_RST   = 11'h000;
  localparam uipc_rx_err_s RX_ERR_RST    = 4'h0;
  localparam uipc_modem_s  MODEM_RST     = 4'h0;

  // Eighths of the FIFO depth for each threshold code
  function automatic int thresh_eighths(input uipc_thresh_e sel);
    case (sel)
      th_one_eighth:    thresh_eighths = 1;
      th_two_eighths:   thresh_eighths = 2;
      th_four_eighths:  thresh_eighths = 4;
      th_six_eighths:   thresh_eighths = 6;
      th_seven_eighths: thresh_eighths = 7;
      default:          thresh_eighths = 4;
    endcase
  endfunction : thresh_eighths

endpackage : uipc_pkg

`default_nettype wire

// >>> uipc_irq_ctrl.sv
// UART interrupt, FIFO threshold, parity and receive error control.
// Assumes FIFO fill levels, character strobes and line events come from logic on sys_clk_in;
// modem lines come from pins and are synchronised here.
//
// Behaviour
// - Transmit threshold: one, two, four, six, seven eighths.
// - Receive threshold chosen independently, same fractions.
// - Threshold selections read back in same encoding.
// - Clear mask drops only the selected sources.
// - Sources stay set until software clears them.
// - Disabled sources never reach the interrupt.
// - Eleven sources: errors, timeout, tx, rx, modem.
// - Raw and masked status both readable.
// - Status, enable, clear share bit layout.
// - Parity none, even, odd, stick one, zero.
// - One parity setting for send and check.
// - Four readable receiver error flags.
// - Overrun flag set when overrun happens.
// - One clear resets all four error flags.
// - Repeat error interrupt needs both clears first.
// - Level mode: tx interrupt on falling past threshold.
// - Idle mode: tx interrupt when fully drained.
`timescale 1ns/1ps
`default_nettype none

module uipc_irq_ctrl
  import uipc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int DATA_W     = 8,
  parameter int FILL_W     = $clog2(FIFO_DEPTH + 1)
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  // Configuration writes
  input  wire logic              thresh_wr_in,
  input  wire logic [2:0]        tx_thresh_sel_in,
  input  wire logic [2:0]        rx_thresh_sel_in,
  input  wire logic              parity_wr_in,
  input  wire logic [2:0]        parity_mode_in,
  input  wire logic              tx_mode_wr_in,
  input  wire logic              tx_mode_in,
  input  wire logic              irq_en_wr_in,
  input  wire uipc_irq_t         irq_en_in,
  input  wire logic              irq_clr_in,
  input  wire uipc_irq_t         irq_clr_mask_in,
  input  wire logic              rx_err_clr_in,
  // Data path observations
  input  wire logic [FILL_W-1:0] tx_fill_in,
  input  wire logic [FILL_W-1:0] rx_fill_in,
  input  wire logic              tx_shift_idle_in,
  input  wire logic [DATA_W-1:0] tx_data_in,
  input  wire logic              rx_char_valid_in,
  input  wire logic [DATA_W-1:0] rx_data_in,
  input  wire logic              rx_parity_in,
  input  wire logic              rx_frame_err_in,
  input  wire logic              rx_break_in,
  input  wire logic              rx_overrun_in,
  input  wire logic              rx_timeout_in,
  input  wire uipc_modem_s       modem_pins_in,
  // Read-back and results
  output logic [2:0]             tx_thresh_sel_out,
  output logic [2:0]             rx_thresh_sel_out,
  output logic [2:0]             parity_mode_out,
  output logic                   tx_mode_out,
  output uipc_irq_t              irq_en_out,
  output uipc_irq_t              irq_raw_out,
  output uipc_irq_t              irq_masked_out,
  output logic                   irq_out,
  output uipc_rx_err_s           rx_err_out,
  output logic                   tx_parity_bit_out
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (FIFO_DEPTH < 8 || (FIFO_DEPTH % 8) != 0) begin : g_bad_depth
    $error("FIFO_DEPTH must be a positive multiple of 8");
  end
  if (DATA_W < 1 || FILL_W < $clog2(FIFO_DEPTH + 1)) begin : g_bad_width
    $error("DATA_W or FILL_W too small");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    uipc_thresh_e tx_sel;
    uipc_thresh_e rx_sel;
    uipc_parity_e parity;
    uipc_txmode_e tx_mode;
    uipc_irq_t    irq_en;
    uipc_irq_t    irq_raw;
    uipc_irq_t    irq_masked;
    logic         irq;
    uipc_rx_err_s rx_err;
    uipc_modem_s  modem_meta;
    uipc_modem_s  modem_sync;
    uipc_modem_s  modem_prev;
    logic         modem_armed;
    logic         tx_above;
    logic         rx_above;
    logic         tx_idle_prev;
    logic         tx_parity;
  } uipc_state_s;

  uipc_state_s st;
  uipc_state_s next_st;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [FILL_W-1:0] thresh_level(input uipc_thresh_e sel);
    thresh_level = FILL_W'((FIFO_DEPTH * thresh_eighths(sel)) / 8);
  endfunction : thresh_level

  // Expected parity bit; stick modes ignore the data entirely
  function automatic logic parity_bit(input uipc_parity_e mode, input logic [DATA_W-1:0] data);
    case (mode)
      parity_even_sel:   parity_bit = ^data;
      parity_odd_sel:    parity_bit = ~^data;
      parity_stick_high: parity_bit = 1'b1;
      parity_stick_low:  parity_bit = 1'b0;
      default:           parity_bit = 1'b0;
    endcase
  endfunction : parity_bit

  function automatic logic thresh_ok(input logic [2:0] code);
    thresh_ok = (code <= 3'(th_seven_eighths));
  endfunction : thresh_ok

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    uipc_rx_err_s ev;
    uipc_irq_t    set;
    uipc_modem_s  change;
    logic         tx_above_now;
    logic         rx_above_now;
    logic         idle_now;
    logic         tx_ev;
    ev           = RX_ERR_RST;
    set          = IRQ_RAW_RST;
    change       = MODEM_RST;
    tx_above_now = 1'b0;
    rx_above_now = 1'b0;
    idle_now     = 1'b0;
    tx_ev        = 1'b0;
    next_st      = st;

    // Configuration; codes outside the encoding are ignored
    if (thresh_wr_in && thresh_ok(tx_thresh_sel_in)) begin
      next_st.tx_sel = uipc_thresh_e'(tx_thresh_sel_in);
    end
    if (thresh_wr_in && thresh_ok(rx_thresh_sel_in)) begin
      next_st.rx_sel = uipc_thresh_e'(rx_thresh_sel_in);
    end
    if (parity_wr_in && parity_mode_in <= 3'(parity_stick_low)) begin
      next_st.parity = uipc_parity_e'(parity_mode_in);
    end
    if (tx_mode_wr_in) begin
      next_st.tx_mode = uipc_txmode_e'(tx_mode_in);
    end
    if (irq_en_wr_in) begin
      next_st.irq_en = irq_en_in;
    end

    // Two-stage synchroniser, then change detect on the settled copy
    next_st.modem_meta  = modem_pins_in;
    next_st.modem_sync  = st.modem_meta;
    next_st.modem_prev  = st.modem_sync;
    next_st.modem_armed = 1'b1;
    // Armed bit masks change detect only in the first cycle after reset, before modem_sync holds the pins
    change = st.modem_armed ? (st.modem_sync ^ st.modem_prev) : MODEM_RST;

    // Transmit interrupt event and receive threshold level
    tx_above_now         = tx_fill_in > thresh_level(st.tx_sel);
    rx_above_now         = rx_fill_in >= thresh_level(st.rx_sel);
    idle_now             = (tx_fill_in == '0) && tx_shift_idle_in;
    next_st.tx_above     = tx_above_now;
    next_st.rx_above     = rx_above_now;
    next_st.tx_idle_prev = idle_now;
    if (st.tx_mode == tx_irq_on_idle) begin
      tx_ev = idle_now && !st.tx_idle_prev;
    end else begin
      tx_ev = st.tx_above && !tx_above_now;
    end

    // Receiver error events
    ev.rx_err_frame      = rx_char_valid_in && rx_frame_err_in;
    ev.rx_err_parity_bit = rx_char_valid_in && (st.parity != parity_off) &&
                           (rx_parity_in != parity_bit(st.parity, rx_data_in));
    ev.rx_err_line_break = rx_break_in;
    ev.rx_err_overflow   = rx_overrun_in;

    // Error interrupts fire only while the matching flag is still clear
    set[irq_overrun]         = ev.rx_err_overflow && !st.rx_err.rx_err_overflow;
    set[irq_line_break]      = ev.rx_err_line_break && !st.rx_err.rx_err_line_break;
    set[irq_parity_fault]    = ev.rx_err_parity_bit && !st.rx_err.rx_err_parity_bit;
    set[irq_frame_fault]     = ev.rx_err_frame && !st.rx_err.rx_err_frame;
    set[irq_rx_idle_timeout] = rx_timeout_in;
    set[irq_tx]              = tx_ev;
    set[irq_rx]              = !st.rx_above && rx_above_now;
    set[irq_dsr]             = change.dsr;
    set[irq_dcd]             = change.dcd;
    set[irq_cts]             = change.cts;
    set[irq_ri]              = change.ri;

    // Sticky status; a new event outranks a clear in the same cycle
    if (irq_clr_in) begin
      next_st.irq_raw = st.irq_raw & ~irq_clr_mask_in;
    end
    next_st.irq_raw = next_st.irq_raw | set;

    if (rx_err_clr_in) begin
      next_st.rx_err = RX_ERR_RST;
    end
    next_st.rx_err = next_st.rx_err | ev;

    next_st.irq_masked = next_st.irq_raw & next_st.irq_en;
    next_st.irq        = |next_st.irq_masked;
    next_st.tx_parity  = parity_bit(next_st.parity, tx_data_in);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st <= '{tx_sel: TX_THRESH_RST, rx_sel: RX_THRESH_RST, parity: PARITY_RST,
              tx_mode: TX_MODE_RST, irq_en: IRQ_EN_RST, irq_raw: IRQ_RAW_RST,
              irq_masked: IRQ_RAW_RST, irq: 1'b0, rx_err: RX_ERR_RST,
              modem_meta: MODEM_RST, modem_sync: MODEM_RST, modem_prev: MODEM_RST,
              modem_armed: 1'b0, tx_above: 1'b0, rx_above: 1'b0,
              tx_idle_prev: 1'b0, tx_parity: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign tx_thresh_sel_out = st.tx_sel;
  assign rx_thresh_sel_out = st.rx_sel;
  assign parity_mode_out   = st.parity;
  assign tx_mode_out       = st.tx_mode;
  assign irq_en_out        = st.irq_en;
  assign irq_raw_out       = st.irq_raw;
  assign irq_masked_out    = st.irq_masked;
  assign irq_out           = st.irq;
  assign rx_err_out        = st.rx_err;
  assign tx_parity_bit_out = st.tx_parity;

endmodule : uipc_irq_ctrl

`default_nettype wire

// >>> uipc_irq_ctrl_asserts.sv
// Concurrent checks on the ports of the interrupt, parity and error block.
// Assumes a single clock domain and attachment by bind from the testbench top.
`timescale 1ns/1ps
`default_nettype none
module uipc_asserts
  import uipc_pkg::*;
(
  input wire logic         sys_clk_in,
  input wire logic         reset_in,
  input wire logic         thresh_wr_in,
  input wire logic         irq_clr_in,
  input wire logic         rx_err_clr_in,
  input wire logic         rx_char_valid_in,
  input wire logic         rx_break_in,
  input wire logic         rx_overrun_in,
  input wire logic         irq_out,
  input wire logic [2:0]   tx_thresh_sel_in,
  input wire logic [2:0]   tx_thresh_sel_out,
  input wire uipc_irq_t    irq_clr_mask_in,
  input wire uipc_irq_t    irq_en_out,
  input wire uipc_irq_t    irq_raw_out,
  input wire uipc_irq_t    irq_masked_out,
  input wire uipc_rx_err_s rx_err_out
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  a_irq_is_or: assert property (irq_out == |irq_masked_out)
    else $error("irq_out not OR of masked");
  a_mask_gates: assert property (irq_masked_out == (irq_raw_out & irq_en_out))
    else $error("masked status wrong");
  a_raw_sticky: assert property (!irq_clr_in |=> (irq_raw_out & $past(irq_raw_out)) == $past(irq_raw_out))
    else $error("raw bit dropped without clear");
  a_clr_drops: assert property (irq_clr_in && irq_clr_mask_in[irq_overrun] && !rx_overrun_in
    |=> !irq_raw_out[irq_overrun]) else $error("clear ignored");
  a_ovr_at_once: assert property (rx_overrun_in |=> rx_err_out.rx_err_overflow)
    else $error("overrun flag late");
  a_err_clr_all: assert property (rx_err_clr_in && !rx_char_valid_in && !rx_break_in && !rx_overrun_in
    |=> rx_err_out == 4'h0) else $error("error flags not cleared");
  a_repeat_held: assert property (rx_overrun_in && rx_err_out.rx_err_overflow && !rx_err_clr_in
    && !irq_raw_out[irq_overrun] |=> !irq_raw_out[irq_overrun]) else $error("repeat error raised irq");
  a_tx_th_load: assert property (thresh_wr_in && tx_thresh_sel_in <= 3'h4
    |=> tx_thresh_sel_out == $past(tx_thresh_sel_in)) else $error("tx threshold not loaded");
endmodule : uipc_asserts
`default_nettype wire

// >>> uipc_peer.sv
// Far-side model: remote sender of characters and modem pin changes.
// Assumes the bench clock; parity follows the block's programmed mode.
`timescale 1ns/1ps
`default_nettype none
module uipc_peer
  import uipc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       send_in,
  input  wire logic [9:0] char_in,
  input  wire logic [2:0] mode_in,
  input  wire logic       flip_in,
  output logic            valid_out,
  output logic [7:0]      data_out,
  output logic            parity_out,
  output logic            frame_err_out,
  output uipc_modem_s     pins_out
);
  // ----------------
  // Line behaviour
  // ----------------
  initial begin
    valid_out = 1'b0;
    data_out  = 8'h00;
    pins_out  = MODEM_RST;
  end
  always @(posedge clk_in) begin
    valid_out     <= send_in;
    data_out      <= send_in ? char_in[7:0] : ~data_out;  // Released data is not held
    frame_err_out <= send_in & char_in[9];
    if (flip_in) pins_out <= pins_out ^ char_in[3:0];
    case (mode_in)
      parity_even_sel:   parity_out <= ^char_in[7:0] ^ char_in[8];
      parity_odd_sel:    parity_out <= ~^char_in[7:0] ^ char_in[8];
      parity_stick_high: parity_out <= ~char_in[8];
      default:           parity_out <= char_in[8];
    endcase
  end
endmodule : uipc_peer
`default_nettype wire

// >>> uipc_irq_ctrl_tb_top.sv
// Self-checking bench for the interrupt, parity and error block.
// Assumes FIFO_DEPTH 16, so levels are 5 bits wide.
`timescale 1ns/1ps
`default_nettype none
module uipc_irq_ctrl_tb_top
  import uipc_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [10:0] strb = 11'h000;
  logic [10:0] val = 11'h000;
  logic [4:0] tx_fill = 5'h00;
  logic [4:0] rx_fill = 5'h00;
  logic shift_idle = 1'b0;
  logic p_valid, p_par, p_ferr, tx_md, irq, txp;
  logic [7:0] p_data;
  logic [2:0] tx_th, rx_th, par_m;
  uipc_modem_s p_pins;
  uipc_rx_err_s err;
  uipc_irq_t en, raw, msk;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  // ----------------
  // Structure
  // ----------------
  always #2 sys_clk_in = ~sys_clk_in;
  uipc_peer u_peer (.clk_in(sys_clk_in), .send_in(strb[9]), .char_in(val[9:0]), .mode_in(par_m),
    .flip_in(strb[10]), .valid_out(p_valid), .data_out(p_data), .parity_out(p_par),
    .frame_err_out(p_ferr), .pins_out(p_pins));
  uipc_irq_ctrl u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .thresh_wr_in(strb[0]),
    .tx_thresh_sel_in(val[2:0]), .rx_thresh_sel_in(val[5:3]), .parity_wr_in(strb[1]), .parity_mode_in(val[2:0]),
    .tx_mode_wr_in(strb[2]), .tx_mode_in(val[0]), .irq_en_wr_in(strb[3]), .irq_en_in(val),
    .irq_clr_in(strb[4]), .irq_clr_mask_in(val), .rx_err_clr_in(strb[5]), .tx_fill_in(tx_fill),
    .rx_fill_in(rx_fill), .tx_shift_idle_in(shift_idle), .tx_data_in(val[10:3]), .rx_char_valid_in(p_valid),
    .rx_data_in(p_data), .rx_parity_in(p_par), .rx_frame_err_in(p_ferr), .rx_break_in(strb[6]),
    .rx_overrun_in(strb[7]), .rx_timeout_in(strb[8]), .modem_pins_in(p_pins), .tx_thresh_sel_out(tx_th),
    .rx_thresh_sel_out(rx_th), .parity_mode_out(par_m), .tx_mode_out(tx_md), .irq_en_out(en),
    .irq_raw_out(raw), .irq_masked_out(msk), .irq_out(irq), .rx_err_out(err), .tx_parity_bit_out(txp));
  // ----------------
  // Tasks
  // ----------------
  task automatic cmp(input string name, input logic [10:0] exp, input logic [10:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic st(input logic [10:0] r, input logic [3:0] e);
    cmp("irq_raw", r, raw);
    cmp("rx_err", {7'h00, e}, {7'h00, err});
  endtask : st
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  // One-cycle strobe with its data; bits 9 and 10 go to the peer
  task automatic hit(input int b, input logic [10:0] v);
    @(posedge sys_clk_in);
    strb[b] <= 1'b1;
    val <= v;
    @(posedge sys_clk_in);
    strb[b] <= 1'b0;
    #1;
  endtask : hit
  task automatic lev(input logic [4:0] t, input logic [4:0] r, input logic i);
    @(posedge sys_clk_in);
    tx_fill <= t;
    rx_fill <= r;
    shift_idle <= i;
    tick(1);
  endtask : lev
  task automatic complete_run;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  // ----------------
  // Tests
  // ----------------
  initial begin
    repeat (16) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    tick(1);
    cmp("rx_thresh", 11'(RX_THRESH_RST), {8'h00, rx_th});
    st(11'h000, 4'h0);
    for (int i = 0; i < 5; i++) begin
      hit(0, 11'((4 - i) * 8 + i));
      cmp("tx_thresh", 11'(i), {8'h00, tx_th});
      cmp("rx_thresh", 11'(4 - i), {8'h00, rx_th});
    end
    hit(0, 11'h02F);
    cmp("rx_thresh", 11'h000, {8'h00, rx_th});
    cmp("tx_thresh", 11'h004, {8'h00, tx_th});
    // Parity off: a flipped parity bit is not an error
    hit(9, 11'h1A5);
    tick(1);
    st(11'h000, 4'h0);
    for (int m = 1; m < 5; m++) begin
      hit(1, 11'h038 | 11'(m));
      tick(1);
      cmp("parity_mode", 11'(m), {8'h00, par_m});
      cmp("tx_parity", 11'(m % 2), {10'h000, txp});
    end
    hit(1, 11'h002);
    hit(9, 11'h0A5);
    tick(1);
    st(11'h000, 4'h0);
    hit(9, 11'h1A5);
    tick(1);
    st(11'h004, 4'h2);
    cmp("irq", 11'h000, {10'h000, irq});
    hit(9, 11'h2A5);
    tick(1);
    st(11'h00C, 4'h3);
    hit(6, 11'h000);
    st(11'h00E, 4'h7);
    hit(3, 11'h7FF);
    tick(1);
    cmp("irq_en", 11'h7FF, en);
    cmp("irq_masked", 11'h00E, msk);
    cmp("irq", 11'h001, {10'h000, irq});
    hit(4, 11'h004);
    st(11'h00A, 4'h7);
    hit(9, 11'h1A5);
    tick(1);
    st(11'h00A, 4'h7);
    hit(7, 11'h000);
    st(11'h00B, 4'hF);
    hit(4, 11'h7FF);
    tick(1);
    cmp("irq", 11'h000, {10'h000, irq});
    hit(7, 11'h000);
    tick(3);
    st(11'h000, 4'hF);
    hit(5, 11'h000);
    st(11'h000, 4'h0);
    hit(7, 11'h000);
    st(11'h001, 4'h8);
    tick(6);
    st(11'h001, 4'h8);
    hit(8, 11'h000);
    st(11'h011, 4'h8);
    hit(3, 11'h010);
    tick(1);
    cmp("irq_masked", 11'h010, msk);
    hit(3, 11'h000);
    tick(1);
    cmp("irq", 11'h000, {10'h000, irq});
    hit(4, 11'h7FF);
    hit(10, 11'h00F);
    tick(5);
    st(11'h780, 4'h8);
    hit(4, 11'h7FF);
    hit(0, 11'h004);
    lev(5'h0F, 5'h01, 1'b0);
    st(11'h000, 4'h8);
    lev(5'h0E, 5'h02, 1'b0);
    st(11'h060, 4'h8);
    hit(4, 11'h7FF);
    hit(2, 11'h001);
    cmp("tx_mode", 11'h001, {10'h000, tx_md});
    lev(5'h01, 5'h00, 1'b1);
    st(11'h000, 4'h8);
    lev(5'h00, 5'h00, 1'b1);
    st(11'h020, 4'h8);
    complete_run();
  end
endmodule : uipc_irq_ctrl_tb_top
bind uipc_irq_ctrl uipc_asserts u_chk (.*);
`default_nettype wire
